// File: logic/adc_trig_pkg.sv
// Purpose: shared constants for the converter trigger and compare block
// Assumes: 8-bit register port with a 4-bit word address
// Notes: all offsets are word indices on the register port
package adc_trig_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CLOCK_SEL = 4'h0;
  localparam logic [3:0] ADDR_TRIG_CFG = 4'h1;
  localparam logic [3:0] ADDR_DELAY_CNT = 4'h2;
  localparam logic [3:0] ADDR_SW_CTRL = 4'h3;
  localparam logic [3:0] ADDR_LOW_BND_L = 4'h4;
  localparam logic [3:0] ADDR_LOW_BND_H = 4'h5;
  localparam logic [3:0] ADDR_HIGH_BND_L = 4'h6;
  localparam logic [3:0] ADDR_HIGH_BND_H = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CLK_SEL_LSB = 0;
  localparam int IN_SEL_LSB = 5;
  localparam int TRIG_SEL_BIT = 7;
  localparam int DLY_EN_BIT = 6;
  localparam int PWM_SRC_BIT = 5;
  localparam int CMP_HI_BIT = 4;
  localparam int CMP_LO_BIT = 3;
  localparam int DUTY_SEL_LSB = 0;
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_CMP_BIT = 1;

  // ------------------------------------------------------------
  // values
  // ------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] IN_SEL_AMP = 3'h1;
  localparam logic [7:0] CLOCK_SEL_RMASK = 8'he7;
  localparam logic [7:0] TRIG_CFG_RMASK = 8'hfb;
  localparam int DIV_CNT_W = 7;
  localparam int DELAY_W = 8;

endpackage

// File: logic/adc_trigger_compare_cfg.sv
// Purpose: conversion clock select, start trigger and window compare for the converter
// Assumes: register port and PWM event flags are synchronous to clk
// Notes: conversion itself is outside; it answers conv_start with conv_done and conv_result
//
// What this block does
// - conversion clock is system clock divided by 1 up to 128 per 3-bit select.
// - trigger select 0 uses software start bit, 1 uses PWM event path.
// - delay enable inserts programmed delay between PWM event and start.
// - source select 0 uses PWM period match, 1 uses chosen duty match.
// - compare condition: between, at-or-below low, at-or-above high, or either.
// - compare interrupt only counts when input select equals 001.
// - duty channel select code 00 picks PWM channel 0 duty match.
// - duty channel select 01 picks channel 1; 10 and 11 pick channel 2.
// - clock-select bits 4 and 3 and trigger-config bit 2 read zero.
// - delay lasts count system clocks from the event flag's rise.
// - software writes start bit high then low; falling write starts conversion.
module adc_trigger_compare_cfg (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // pwm events
  input wire logic pwm_period_match_evt,
  input wire logic [2:0] pwm_duty_match_evt,
  // converter side
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  output logic conv_start,
  output logic conv_clk_tick,
  output logic conv_busy,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] clock_sel_reg;
  logic [7:0] conversion_trigger_config_reg;
  logic [7:0] start_delay_count_reg;
  logic start_bit_reg;
  logic [11:0] low_bound_value_reg;
  logic [11:0] high_bound_value_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] rd_data_reg;
  logic conv_start_reg;
  logic conv_clk_tick_reg;
  logic busy_reg;
  logic irq_reg;
  logic period_prev_reg;
  logic [2:0] duty_prev_reg;

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  wire [2:0] conv_clock_div_sel = clock_sel_reg[adc_trig_pkg::CLK_SEL_LSB +: 3];
  wire [2:0] input_signal_sel = clock_sel_reg[adc_trig_pkg::IN_SEL_LSB +: 3];
  wire start_trigger_sel = conversion_trigger_config_reg[adc_trig_pkg::TRIG_SEL_BIT];
  wire delay_start_en = conversion_trigger_config_reg[adc_trig_pkg::DLY_EN_BIT];
  wire pwm_event_src_sel = conversion_trigger_config_reg[adc_trig_pkg::PWM_SRC_BIT];
  wire cmp_cond_hi = conversion_trigger_config_reg[adc_trig_pkg::CMP_HI_BIT];
  wire cmp_cond_lo = conversion_trigger_config_reg[adc_trig_pkg::CMP_LO_BIT];
  wire [1:0] duty_event_chan_sel = conversion_trigger_config_reg[adc_trig_pkg::DUTY_SEL_LSB +: 2];

  wire hit_clock_sel = (addr == adc_trig_pkg::ADDR_CLOCK_SEL);
  wire hit_trig_cfg = (addr == adc_trig_pkg::ADDR_TRIG_CFG);
  wire hit_delay_cnt = (addr == adc_trig_pkg::ADDR_DELAY_CNT);
  wire hit_sw_ctrl = (addr == adc_trig_pkg::ADDR_SW_CTRL);
  wire hit_low_l = (addr == adc_trig_pkg::ADDR_LOW_BND_L);
  wire hit_low_h = (addr == adc_trig_pkg::ADDR_LOW_BND_H);
  wire hit_high_l = (addr == adc_trig_pkg::ADDR_HIGH_BND_L);
  wire hit_high_h = (addr == adc_trig_pkg::ADDR_HIGH_BND_H);
  wire hit_status = (addr == adc_trig_pkg::ADDR_IRQ_STATUS);
  wire hit_mask = (addr == adc_trig_pkg::ADDR_IRQ_MASK);

  // ------------------------------------------------------------
  // software start path
  // ------------------------------------------------------------
  // a conversion begins on the write that takes the bit from one to zero
  wire start_bit_write = wr_en && hit_sw_ctrl;
  wire start_bit_new = wr_data[adc_trig_pkg::START_BIT];
  wire sw_start = start_bit_write && start_bit_reg && !start_bit_new
                  && !start_trigger_sel;

  // ------------------------------------------------------------
  // pwm event path
  // ------------------------------------------------------------
  logic duty_sel_evt;
  logic duty_sel_prev;
  always_comb begin
    case (duty_event_chan_sel)
      2'b00: begin
        duty_sel_evt = pwm_duty_match_evt[0];
        duty_sel_prev = duty_prev_reg[0];
      end
      2'b01: begin
        duty_sel_evt = pwm_duty_match_evt[1];
        duty_sel_prev = duty_prev_reg[1];
      end
      default: begin
        duty_sel_evt = pwm_duty_match_evt[2];
        duty_sel_prev = duty_prev_reg[2];
      end
    endcase
  end

  wire src_evt = pwm_event_src_sel ? duty_sel_evt : pwm_period_match_evt;
  wire src_prev = pwm_event_src_sel ? duty_sel_prev : period_prev_reg;
  // only the flag's rise counts, so a flag left high cannot retrigger
  wire pwm_rise = src_evt && !src_prev && start_trigger_sel;

  logic delay_fire;
  start_delay_timer u_delay (
    .clk(clk),
    .rst(rst),
    .launch(pwm_rise),
    .delay_en(delay_start_en),
    .delay_count(start_delay_count_reg),
    .fire(delay_fire),
    .counting()
  );

  wire pwm_start = delay_fire && start_trigger_sel;
  wire start_any = sw_start || pwm_start;

  // ------------------------------------------------------------
  // conversion clock
  // ------------------------------------------------------------
  logic div_tick;
  conv_clock_divider u_div (
    .clk(clk),
    .rst(rst),
    .div_sel(conv_clock_div_sel),
    .tick(div_tick)
  );

  // ------------------------------------------------------------
  // window compare
  // ------------------------------------------------------------
  wire at_or_below_low = (conv_result <= low_bound_value_reg);
  wire at_or_above_high = (conv_result >= high_bound_value_reg);
  wire inside_window = (conv_result > low_bound_value_reg)
                       && (conv_result < high_bound_value_reg);
  logic cmp_match;
  always_comb begin
    case ({cmp_cond_hi, cmp_cond_lo})
      2'b00: cmp_match = inside_window;
      2'b01: cmp_match = at_or_below_low;
      2'b10: cmp_match = at_or_above_high;
      default: cmp_match = at_or_below_low || at_or_above_high;
    endcase
  end
  wire cmp_event = conv_done && cmp_match
                   && (input_signal_sel == adc_trig_pkg::IN_SEL_AMP);

  // ------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------
  wire [1:0] status_set = {cmp_event, conv_done};
  wire [1:0] status_clr = (wr_en && hit_status) ? wr_data[1:0] : 2'b00;
  // a set in the same cycle as its clear survives
  wire [1:0] status_next = (irq_status_reg & ~status_clr) | status_set;
  wire irq_next = |(status_next & irq_mask_reg);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit_clock_sel) begin
      rd_mux = clock_sel_reg & adc_trig_pkg::CLOCK_SEL_RMASK;
    end else if (hit_trig_cfg) begin
      rd_mux = conversion_trigger_config_reg & adc_trig_pkg::TRIG_CFG_RMASK;
    end else if (hit_delay_cnt) begin
      rd_mux = start_delay_count_reg;
    end else if (hit_sw_ctrl) begin
      rd_mux = {start_bit_reg, busy_reg, 6'h00};
    end else if (hit_low_l) begin
      rd_mux = low_bound_value_reg[7:0];
    end else if (hit_low_h) begin
      rd_mux = {4'h0, low_bound_value_reg[11:8]};
    end else if (hit_high_l) begin
      rd_mux = high_bound_value_reg[7:0];
    end else if (hit_high_h) begin
      rd_mux = {4'h0, high_bound_value_reg[11:8]};
    end else if (hit_status) begin
      rd_mux = {6'h00, irq_status_reg};
    end else if (hit_mask) begin
      rd_mux = {6'h00, irq_mask_reg};
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_sel_reg <= adc_trig_pkg::RESET_BYTE;
      conversion_trigger_config_reg <= adc_trig_pkg::RESET_BYTE;
      start_delay_count_reg <= adc_trig_pkg::RESET_BYTE;
      irq_mask_reg <= 2'b00;
    end else if (wr_en) begin
      if (hit_clock_sel) clock_sel_reg <= wr_data & adc_trig_pkg::CLOCK_SEL_RMASK;
      if (hit_trig_cfg) conversion_trigger_config_reg <= wr_data & adc_trig_pkg::TRIG_CFG_RMASK;
      if (hit_delay_cnt) start_delay_count_reg <= wr_data;
      if (hit_mask) irq_mask_reg <= wr_data[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_bound_value_reg <= 12'h000;
      high_bound_value_reg <= 12'h000;
    end else if (wr_en) begin
      if (hit_low_l) low_bound_value_reg[7:0] <= wr_data;
      if (hit_low_h) low_bound_value_reg[11:8] <= wr_data[3:0];
      if (hit_high_l) high_bound_value_reg[7:0] <= wr_data;
      if (hit_high_h) high_bound_value_reg[11:8] <= wr_data[3:0];
    end
  end

  // ------------------------------------------------------------
  // state and outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      start_bit_reg <= 1'b0;
      period_prev_reg <= 1'b0;
      duty_prev_reg <= 3'h0;
      busy_reg <= 1'b0;
      conv_start_reg <= 1'b0;
    end else begin
      if (start_bit_write) start_bit_reg <= start_bit_new;
      period_prev_reg <= pwm_period_match_evt;
      duty_prev_reg <= pwm_duty_match_evt;
      conv_start_reg <= start_any;
      // a new start wins over a finishing conversion
      busy_reg <= start_any || (busy_reg && !conv_done);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_reg <= 2'b00;
      irq_reg <= 1'b0;
      rd_data_reg <= 8'h00;
      conv_clk_tick_reg <= 1'b0;
    end else begin
      irq_status_reg <= status_next;
      irq_reg <= irq_next;
      rd_data_reg <= rd_en ? rd_mux : 8'h00;
      conv_clk_tick_reg <= div_tick;
    end
  end

  assign rd_data = rd_data_reg;
  assign conv_start = conv_start_reg;
  assign conv_clk_tick = conv_clk_tick_reg;
  assign conv_busy = busy_reg;
  assign irq = irq_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_sw_fall;
    !start_trigger_sel && wr_en && hit_sw_ctrl && start_bit_reg && !start_bit_new;
  endsequence

  a_sw_start_fall: assert property (@(posedge clk) disable iff (rst)
    s_sw_fall |=> conv_start ##1 conv_busy)
    else $error("software start sequence did not start a conversion");

  a_sw_path_quiet: assert property (@(posedge clk) disable iff (rst)
    (!start_trigger_sel && !sw_start) |=> !conv_start)
    else $error("start issued on software path without start sequence");

  a_period_nodelay: assert property (@(posedge clk) disable iff (rst)
    (start_trigger_sel && !delay_start_en && !pwm_event_src_sel
     && pwm_period_match_evt && !period_prev_reg) |=> conv_start)
    else $error("period match did not start a conversion");

  a_duty_chan_two: assert property (@(posedge clk) disable iff (rst)
    (start_trigger_sel && !delay_start_en && pwm_event_src_sel
     && duty_event_chan_sel == 2'b11 && pwm_duty_match_evt[2] && !duty_prev_reg[2])
    |=> conv_start)
    else $error("duty channel two did not start a conversion");

  a_delay_holds: assert property (@(posedge clk) disable iff (rst)
    (pwm_rise && delay_start_en && start_delay_count_reg == 8'h03)
    |=> !conv_start ##1 !conv_start)
    else $error("delayed start came early");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (rd_en && (hit_clock_sel || hit_trig_cfg)) |=> (rd_data[4:3] == 2'b00 || $past(hit_trig_cfg))
    && (rd_data[2] == 1'b0 || $past(hit_clock_sel)))
    else $error("unimplemented bits read nonzero");

  a_cmp_gate: assert property (@(posedge clk) disable iff (rst)
    (conv_done && input_signal_sel != adc_trig_pkg::IN_SEL_AMP
     && !irq_status_reg[adc_trig_pkg::ST_CMP_BIT])
    |=> !irq_status_reg[adc_trig_pkg::ST_CMP_BIT])
    else $error("compare flagged with wrong input select");

  a_cmp_high: assert property (@(posedge clk) disable iff (rst)
    (conv_done && input_signal_sel == adc_trig_pkg::IN_SEL_AMP
     && {cmp_cond_hi, cmp_cond_lo} == 2'b10 && conv_result >= high_bound_value_reg)
    |=> irq_status_reg[adc_trig_pkg::ST_CMP_BIT])
    else $error("high bound compare missed");

  sequence s_pwm_now;
    start_trigger_sel && !delay_start_en && pwm_rise;
  endsequence

  a_pwm_immediate: assert property (@(posedge clk) disable iff (rst)
    s_pwm_now |=> conv_start)
    else $error("undelayed pwm event did not start a conversion");

  a_duty_chan_zero: assert property (@(posedge clk) disable iff (rst)
    (start_trigger_sel && !delay_start_en && pwm_event_src_sel
     && duty_event_chan_sel == 2'b00 && pwm_duty_match_evt[0] && !duty_prev_reg[0])
    |=> conv_start)
    else $error("duty channel zero did not start a conversion");

  a_duty_chan_one: assert property (@(posedge clk) disable iff (rst)
    (start_trigger_sel && !delay_start_en && pwm_event_src_sel
     && duty_event_chan_sel == 2'b01 && pwm_duty_match_evt[1] && !duty_prev_reg[1])
    |=> conv_start)
    else $error("duty channel one did not start a conversion");

  a_cmp_inside: assert property (@(posedge clk) disable iff (rst)
    (conv_done && input_signal_sel == adc_trig_pkg::IN_SEL_AMP
     && {cmp_cond_hi, cmp_cond_lo} == 2'b00 && conv_result > low_bound_value_reg
     && conv_result < high_bound_value_reg)
    |=> irq_status_reg[adc_trig_pkg::ST_CMP_BIT])
    else $error("inside window compare missed");

  a_cmp_low: assert property (@(posedge clk) disable iff (rst)
    (conv_done && input_signal_sel == adc_trig_pkg::IN_SEL_AMP
     && {cmp_cond_hi, cmp_cond_lo} == 2'b01 && conv_result <= low_bound_value_reg)
    |=> irq_status_reg[adc_trig_pkg::ST_CMP_BIT])
    else $error("low bound compare missed");

endmodule

// File: logic/conv_clock_divider.sv
// Purpose: conversion clock tick, system clock divided by 2**sel
// Assumes: sel is a register output, stable most of the time
// Notes: tick is combinational; the caller registers it
module conv_clock_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic [2:0] div_sel,
  // result
  output logic tick
);

  logic [adc_trig_pkg::DIV_CNT_W-1:0] div_cnt_reg;
  logic [adc_trig_pkg::DIV_CNT_W-1:0] div_cnt_next;
  logic [adc_trig_pkg::DIV_CNT_W-1:0] low_mask;

  // low bits that must be all ones for a tick
  genvar i;
  generate
    for (i = 0; i < adc_trig_pkg::DIV_CNT_W; i++) begin : g_mask
      assign low_mask[i] = (div_sel > 3'(i));
    end
  endgenerate

  assign div_cnt_next = div_cnt_reg + 7'h01;
  assign tick = ((div_cnt_reg & low_mask) == low_mask);

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_reg <= 7'h00;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  a_div_undivided: assert property (@(posedge clk) disable iff (rst)
    (div_sel == 3'h0) |-> tick)
    else $error("undivided clock missed a tick");

  a_div_by_128: assert property (@(posedge clk) disable iff (rst)
    (tick && div_sel == 3'h7 && $stable(div_sel)) |=> (!tick || div_sel != 3'h7)[*8])
    else $error("divide by 128 ticked too soon");

endmodule

// File: logic/start_delay_timer.sv
// Purpose: counts the programmed start delay after a trigger event
// Assumes: launch is a one-cycle pulse
// Notes: a new launch while counting restarts the delay
module start_delay_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic launch,
  input wire logic delay_en,
  input wire logic [7:0] delay_count,
  // result
  output logic fire,
  output logic counting
);

  logic [adc_trig_pkg::DELAY_W-1:0] cnt_reg;
  logic [adc_trig_pkg::DELAY_W-1:0] cnt_next;
  logic immediate;

  // a zero count with the delay on is a software slip; start at once
  assign immediate = launch && (!delay_en || delay_count == 8'h00);
  assign fire = immediate || (!launch && cnt_reg == 8'h01);
  assign counting = (cnt_reg != 8'h00);

  always_comb begin
    cnt_next = cnt_reg;
    if (launch) begin
      cnt_next = delay_en ? delay_count : 8'h00;
    end else if (cnt_reg != 8'h00) begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  sequence s_launch_two;
    launch && delay_en && delay_count == 8'h02;
  endsequence

  sequence s_wait_two;
    (!fire && !launch) ##1 (fire || launch);
  endsequence

  a_delay_length: assert property (@(posedge clk) disable iff (rst)
    s_launch_two |=> s_wait_two)
    else $error("delay of two cycles not kept");

endmodule

// File: tb/adc_trigger_compare_cfg_tb.sv
// Purpose: self-checking bench for the converter trigger and compare block
// Assumes: register port with read data one cycle after the strobe
// Notes: delays are counted in negedges after the edge that raises a flag
module adc_trigger_compare_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] rd_data;
  logic pwm_period_match_evt = 1'b0;
  logic [2:0] pwm_duty_match_evt = 3'h0;
  logic conv_done;
  logic [11:0] conv_result;
  logic conv_start;
  logic conv_clk_tick;
  logic conv_busy;
  logic irq;
  logic [11:0] res_value = 12'h000;
  int bad_count = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  adc_trigger_compare_cfg dut (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .pwm_period_match_evt(pwm_period_match_evt),
    .pwm_duty_match_evt(pwm_duty_match_evt), .conv_done(conv_done),
    .conv_result(conv_result), .conv_start(conv_start), .conv_clk_tick(conv_clk_tick),
    .conv_busy(conv_busy), .irq(irq)
  );

  conv_model conv (
    .clk(clk), .rst(rst), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result), .res_value(res_value)
  );

  // ----------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check({8'h00, rd_data}, {8'h00, exp});
  endtask

  task automatic sw_start(output logic seen);
    wr(adc_trig_pkg::ADDR_SW_CTRL, 8'h80);
    wr(adc_trig_pkg::ADDR_SW_CTRL, 8'h00);
    @(negedge clk);
    seen = conv_start;
  endtask

  task automatic wait_done();
    int i;
    i = 0;
    while (conv_done !== 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    repeat (3) @(negedge clk);
  endtask

  // which: 0 period flag, 1..3 duty flag of channel 0..2; n 0 means no start
  task automatic pwm_try(input int which, output int n);
    int i;
    @(posedge clk);
    if (which == 0) begin
      pwm_period_match_evt <= 1'b1;
    end else begin
      pwm_duty_match_evt[which-1] <= 1'b1;
    end
    n = 0;
    for (i = 1; i <= 30 && n == 0; i++) begin
      @(negedge clk);
      if (conv_start === 1'b1) begin
        n = i;
      end
    end
    @(posedge clk);
    pwm_period_match_evt <= 1'b0;
    pwm_duty_match_evt <= 3'h0;
    repeat (12) @(posedge clk);
  endtask

  // second interval only: the first may be cut short by the select change
  task automatic tick_period(output int p);
    int i;
    i = 0;
    @(negedge clk);
    while (conv_clk_tick !== 1'b1 && i < 300) begin
      @(negedge clk);
      i++;
    end
    for (i = 0; i < 2; i++) begin
      p = 0;
      do begin
        @(negedge clk);
        p++;
      end while (conv_clk_tick !== 1'b1 && p < 300);
    end
  endtask

  function automatic logic cmp_exp(input int c, input int r);
    case (c)
      0: return r > 100 && r < 200;
      1: return r <= 100;
      2: return r >= 200;
      default: return r <= 100 || r >= 200;
    endcase
  endfunction

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  logic [7:0] cfgs [11] = '{8'h80, 8'h80, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha1, 8'hc0,
    8'hc0, 8'hc0, 8'h00};
  int dlys [11] = '{0, 0, 0, 0, 0, 0, 0, 1, 2, 3, 0};
  int srcs [11] = '{0, 1, 1, 2, 3, 3, 1, 0, 0, 0, 0};
  int expn [11] = '{2, 0, 2, 2, 2, 2, 0, 3, 4, 5, 0};
  int vals [5] = '{50, 100, 150, 200, 250};

  initial begin
    int n;
    logic seen;
    logic e;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 10; a++) begin
      rd_check(4'(a), 8'h00);
    end
    wr(4'hf, 8'hff);
    rd_check(4'hf, 8'h00);
    wr(adc_trig_pkg::ADDR_CLOCK_SEL, 8'hff);
    rd_check(adc_trig_pkg::ADDR_CLOCK_SEL, 8'he7);
    wr(adc_trig_pkg::ADDR_DELAY_CNT, 8'hff);
    rd_check(adc_trig_pkg::ADDR_DELAY_CNT, 8'hff);
    wr(adc_trig_pkg::ADDR_TRIG_CFG, 8'hff);
    rd_check(adc_trig_pkg::ADDR_TRIG_CFG, 8'hfb);
    wr(adc_trig_pkg::ADDR_TRIG_CFG, 8'h00);
    wr(adc_trig_pkg::ADDR_DELAY_CNT, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(adc_trig_pkg::ADDR_CLOCK_SEL, 8'(s));
      tick_period(n);
      check(16'(n), 16'(1 << s));
    end
    wr(adc_trig_pkg::ADDR_CLOCK_SEL, 8'h00);
    sw_start(seen);
    check({15'h0000, seen}, 16'h0001);
    @(negedge clk);
    check({15'h0000, conv_busy}, 16'h0001);
    rd_check(adc_trig_pkg::ADDR_SW_CTRL, 8'h40);
    wait_done();
    rd_check(adc_trig_pkg::ADDR_SW_CTRL, 8'h00);
    rd_check(adc_trig_pkg::ADDR_IRQ_STATUS, 8'h01);
    wr(adc_trig_pkg::ADDR_IRQ_STATUS, 8'h01);
    rd_check(adc_trig_pkg::ADDR_IRQ_STATUS, 8'h00);
    wr(adc_trig_pkg::ADDR_TRIG_CFG, 8'h80);
    sw_start(seen);
    check({15'h0000, seen}, 16'h0000);
    // delay enable is raised only after the count is loaded
    for (int i = 0; i < 11; i++) begin
      wr(adc_trig_pkg::ADDR_TRIG_CFG, cfgs[i] & 8'hbf);
      wr(adc_trig_pkg::ADDR_DELAY_CNT, 8'(dlys[i]));
      wr(adc_trig_pkg::ADDR_TRIG_CFG, cfgs[i]);
      pwm_try(srcs[i], n);
      check(16'(n), 16'(expn[i]));
    end
    wr(adc_trig_pkg::ADDR_CLOCK_SEL, 8'h20);
    wr(adc_trig_pkg::ADDR_LOW_BND_L, 8'h64);
    wr(adc_trig_pkg::ADDR_HIGH_BND_L, 8'hc8);
    wr(adc_trig_pkg::ADDR_IRQ_MASK, 8'h02);
    rd_check(adc_trig_pkg::ADDR_HIGH_BND_L, 8'hc8);
    rd_check(adc_trig_pkg::ADDR_IRQ_MASK, 8'h02);
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 5; v++) begin
        wr(adc_trig_pkg::ADDR_TRIG_CFG, 8'(c << 3));
        res_value <= 12'(vals[v]);
        sw_start(seen);
        wait_done();
        e = cmp_exp(c, vals[v]);
        rd_check(adc_trig_pkg::ADDR_IRQ_STATUS, {6'h00, e, 1'b1});
        check({15'h0000, irq}, {15'h0000, e});
        wr(adc_trig_pkg::ADDR_IRQ_STATUS, 8'h03);
        repeat (2) @(negedge clk);
        check({15'h0000, irq}, 16'h0000);
      end
    end
    // amplifier not routed: the compare bit must stay clear
    wr(adc_trig_pkg::ADDR_CLOCK_SEL, 8'h00);
    wr(adc_trig_pkg::ADDR_IRQ_MASK, 8'h03);
    wr(adc_trig_pkg::ADDR_TRIG_CFG, 8'h08);
    res_value <= 12'h032;
    sw_start(seen);
    wait_done();
    rd_check(adc_trig_pkg::ADDR_IRQ_STATUS, 8'h01);
    check({15'h0000, irq}, 16'h0001);
    wr(adc_trig_pkg::ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(negedge clk);
    check({15'h0000, irq}, 16'h0000);
    print_verdict();
  end

  // whole run is a few thousand cycles; this leaves a wide margin
  initial begin
    #200us;
    bad_count++;
    print_verdict();
  end
endmodule

// File: tb/conv_model.sv
// Purpose: behavioural converter that answers conv_start with a result
// Assumes: one conversion at a time, started by a one-cycle conv_start
// Notes: result lines carry the inverse of the last result outside conv_done
module conv_model #(
  parameter int LATENCY = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // block side
  input wire logic conv_start,
  output logic conv_done,
  output logic [11:0] conv_result,
  // bench side
  input wire logic [11:0] res_value
);
  timeunit 1ns;
  timeprecision 1ps;
  int count = 0;
  logic [11:0] last = 12'h000;

  // held result would hide a block that samples outside conv_done
  always @(posedge clk) begin
    conv_done <= 1'b0;
    if (rst) begin
      count <= 0;
      conv_result <= 12'h000;
    end else if (conv_start) begin
      count <= LATENCY;
    end else if (count > 0) begin
      count <= count - 1;
      if (count == 1) begin
        conv_done <= 1'b1;
        conv_result <= res_value;
        last <= res_value;
      end
    end else begin
      conv_result <= ~last;
    end
  end
endmodule
